// ### testbench/rsc_far_model.sv
`timescale 1ns/100ps
module rsc_far_model (
    input  wire logic ref_clk_i,
    input  wire logic pin_pullup_i,
    input  wire logic pin_oe_n_i,
    output logic      supply_good_o,
    output logic      supply_at_ground_o,
    output logic      brownout_ok_o,
    output logic      wdt_expired_o,
    output logic      pin_o
);
    logic pin_low_r;
    logic float_r;
    initial begin
        supply_good_o = 1'b0;
        supply_at_ground_o = 1'b0;
        brownout_ok_o = 1'b1;
        wdt_expired_o = 1'b0;
        pin_low_r = 1'b0;
        float_r = 1'b0;
    end
    // A floating pin toggles so a stale level is never mistaken for a driven one
    always @(posedge ref_clk_i) float_r <= ~float_r;
    assign pin_o = (pin_low_r || !pin_oe_n_i) ? 1'b0 : (pin_pullup_i ? 1'b1 : float_r);
    task automatic set_supply(input logic good, input logic gnd);
        supply_good_o <= good;
        supply_at_ground_o <= gnd;
    endtask
    task automatic set_bor(input logic ok);
        brownout_ok_o <= ok;
    endtask
    task automatic wdt_pulse();
        wdt_expired_o <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        wdt_expired_o <= 1'b0;
    endtask
    task automatic pin_pulse(input int len);
        pin_low_r <= 1'b1;
        repeat (len) @(posedge ref_clk_i);
        pin_low_r <= 1'b0;
    endtask
endmodule

// ### testbench/rsc_reset_ctrl_asserts.sv
`timescale 1ns/100ps
module rsc_reset_ctrl_asserts #(
    parameter int unsigned PIN_MIN_CYC = rsc_pkg::PIN_FILT_CYC
) (
    input wire logic       ref_clk_i,
    input wire logic       sys_rst_i,
    input wire logic       brownout_enable_i,
    input wire logic       brownout_ok_i,
    input wire logic       shared_input_pin_i,
    input wire logic       ext_reset_pin_enable_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       shared_pin_pullup_o,
    input wire logic       shared_pin_oe_n_o,
    input wire logic       core_rst_n_o,
    input wire logic       retained_rst_n_o,
    input wire logic       wake_o
);
    logic [7:0] low_cnt_r;
    // Saturating count of enabled pin-low cycles; margin covers sync and output stages
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || shared_input_pin_i || !ext_reset_pin_enable_i) begin
            low_cnt_r <= 8'h00;
        end else if (low_cnt_r != 8'hff) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_no_drive; shared_pin_oe_n_o; endproperty
    property p_pullup; shared_pin_pullup_o == ext_reset_pin_enable_i; endproperty
    property p_pin_rst; low_cnt_r > PIN_MIN_CYC + 6 |-> !core_rst_n_o; endproperty
    property p_ret_core; !retained_rst_n_o |-> !core_rst_n_o; endproperty
    property p_bor_hold; (brownout_enable_i && !brownout_ok_i) [*6] |-> !core_rst_n_o; endproperty
    property p_wake; wake_o |-> core_rst_n_o ##1 !wake_o; endproperty
    property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
    property p_unmapped; reg_rd_i && reg_addr_i > 4'h3 |=> reg_rdata_o == 8'h00; endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("reset block drives the pin");
    a_pullup: assert property (p_pullup)
        else $error("pull-up does not follow pin enable");
    a_pin_rst: assert property (p_pin_rst)
        else $error("long pin low gave no reset");
    a_ret_core: assert property (p_ret_core)
        else $error("retained reset without core reset");
    a_bor_hold: assert property (p_bor_hold)
        else $error("core released below brown-out threshold");
    a_wake: assert property (p_wake)
        else $error("wake pulse with reset or too long");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    c_wake: cover property (wake_o);
    c_release: cover property ($rose(core_rst_n_o));
    c_por: cover property ($fell(retained_rst_n_o));
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_asserts #(.PIN_MIN_CYC(PIN_MIN_CYC)) u_chk (
    .ref_clk_i, .sys_rst_i, .brownout_enable_i, .brownout_ok_i, .shared_input_pin_i,
    .ext_reset_pin_enable_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .shared_pin_pullup_o,
    .shared_pin_oe_n_o, .core_rst_n_o, .retained_rst_n_o, .wake_o
);

// ### testbench/tb_reset_source_control.sv
`timescale 1ns/100ps
module tb_reset_source_control;
    localparam int unsigned PW = 20;
    localparam int unsigned PM = 4;
    logic       ref_clk_i, sys_rst_i, ce_i, brownout_enable_i, brownout_ok_i;
    logic       supply_good_i, supply_at_ground_i, watchdog_timer_expired_i;
    logic       shared_input_pin_i, ext_reset_pin_enable_i, powerup_delay_disable_i;
    logic       reg_wr_i, reg_rd_i, shared_pin_pullup_o, shared_pin_oe_n_o;
    logic       shared_pin_gpio_o, core_rst_n_o, retained_rst_n_o, wake_o, irq_o;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    int         n_fail, total_checks, core_low, ret_low, wakes, n, m_code, m_to, m_pd, m_bf;
    int         ev_q[$];
    rsc_reset_ctrl #(.PWRUP_CYCLES(PW), .PIN_MIN_CYC(PM)) dut (
        .ref_clk_i, .sys_rst_i, .ce_i, .supply_good_i, .supply_at_ground_i,
        .brownout_enable_i, .brownout_ok_i, .watchdog_timer_expired_i,
        .shared_input_pin_i, .ext_reset_pin_enable_i, .powerup_delay_disable_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .shared_pin_pullup_o, .shared_pin_oe_n_o, .shared_pin_gpio_o, .core_rst_n_o,
        .retained_rst_n_o, .wake_o, .irq_o
    );
    rsc_far_model far (
        .ref_clk_i, .pin_pullup_i(shared_pin_pullup_o), .pin_oe_n_i(shared_pin_oe_n_o),
        .supply_good_o(supply_good_i), .supply_at_ground_o(supply_at_ground_i),
        .brownout_ok_o(brownout_ok_i), .wdt_expired_o(watchdog_timer_expired_i),
        .pin_o(shared_input_pin_i)
    );
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (core_rst_n_o === 1'b0) core_low++;
        if (retained_rst_n_o === 1'b0) ret_low++;
        if (wake_o === 1'b1) wakes++;
    end
    task automatic summarize();
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge ref_clk_i);
        #1;
    endtask
    // Strobe is dropped and a step passes, so back-to-back calls never clash
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk((reg_rdata_o & m) === (e & m), "register read mismatch");
    endtask
    task automatic wait_core(output int c);
        c = 0;
        while (core_rst_n_o !== 1'b1) begin
            idle(1);
            c++;
            if (c > 300) begin
                chk(1'b0, "core reset never released");
                summarize();
            end
        end
    endtask
    task automatic model(input int code, input int to, input int pd, input int ev);
        m_code = code;
        if (to >= 0) m_to = to;
        m_pd = pd;
        ev_q.push_back(ev);
    endtask
    task automatic check_after(input logic [7:0] m);
        int ev;
        ev = ev_q.pop_front();
        rd(rsc_pkg::ADDR_CAUSE, 8'((m_code << 4) | (m_to << 2) | (m_pd << 1) | m_bf), m);
        rd(rsc_pkg::ADDR_STATUS, 8'(1 << ev), 8'(1 << ev));
        wr(rsc_pkg::ADDR_STATUS, 8'h1f);
    endtask
    task automatic pin_event(input int len, input logic rst_exp);
        core_low = 0;
        far.pin_pulse(len);
        idle(10);
        chk((core_low > 0) === rst_exp, "pin reset response");
        wait_core(n);
    endtask
    initial begin
        n = $urandom(32'h4f46);
        {sys_rst_i, ce_i, brownout_enable_i, powerup_delay_disable_i} = 4'b1100;
        {ext_reset_pin_enable_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        {n_fail, total_checks, ret_low, m_bf} = '0;
        repeat (20) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        idle(30);
        chk(core_rst_n_o === 1'b0, "released with supply low");
        rd(rsc_pkg::ADDR_MASK, rsc_pkg::MASK_RST, 8'hff);
        wr(4'h9, 8'($urandom));
        rd(4'h9, 8'h00, 8'hff);
        far.set_supply(1'b1, 1'b0);
        wait_core(n);
        chk(n > PW && retained_rst_n_o === 1'b1, "power-up release");
        model(1, 1, 1, rsc_pkg::EV_POR);
        check_after(8'hf6);
        wr(rsc_pkg::ADDR_CTRL, 8'h02);
        m_bf = 1;
        pin_event(30, 1'b0);
        chk(shared_pin_pullup_o === 1'b0, "pull-up while pin disabled");
        ext_reset_pin_enable_i <= 1'b1;
        pin_event(1 + $urandom % 2, 1'b0);
        chk(shared_pin_pullup_o === 1'b1, "pull-up off");
        pin_event(PM + 6 + $urandom % 8, 1'b1);
        model(5, -1, 1, rsc_pkg::EV_PIN);
        check_after(8'hf7);
        core_low = 0;
        far.wdt_pulse();
        idle(10);
        wait_core(n);
        chk(core_low > 0 && shared_pin_oe_n_o === 1'b1, "watchdog reset");
        model(3, 0, 1, rsc_pkg::EV_WDT);
        check_after(8'hf7);
        wr(rsc_pkg::ADDR_CTRL, 8'h01);
        core_low = 0;
        wakes = 0;
        far.wdt_pulse();
        idle(10);
        chk(core_low == 0 && wakes == 1, "watchdog wake");
        model(7, 0, 0, rsc_pkg::EV_WAKE);
        chk(irq_o === 1'b0, "irq while masked");
        wr(rsc_pkg::ADDR_MASK, 8'h10);
        chk(irq_o === 1'b1, "irq missing");
        check_after(8'hf7);
        chk(irq_o === 1'b0, "irq not cleared");
        wr(rsc_pkg::ADDR_MASK, 8'h00);
        wr(rsc_pkg::ADDR_CTRL, 8'h01);
        pin_event(PM + 8, 1'b1);
        model(6, -1, 0, rsc_pkg::EV_PIN);
        check_after(8'hf7);
        ret_low = 0;
        brownout_enable_i <= 1'b1;
        far.set_bor(1'b0);
        idle(10);
        chk(core_rst_n_o === 1'b0, "no brown-out reset");
        far.set_bor(1'b1);
        wait_core(n);
        chk(n > PW && ret_low == 0, "brown-out release");
        model(2, 1, 1, rsc_pkg::EV_BOR);
        m_bf = 0;
        check_after(8'hf7);
        brownout_enable_i <= 1'b0;
        far.set_supply(1'b0, 1'b0);
        core_low = 0;
        idle(40);
        chk(core_low == 0, "reset on falling supply");
        far.set_supply(1'b0, 1'b1);
        idle(rsc_pkg::REARM_CYCLES + 100);
        far.set_supply(1'b1, 1'b0);
        idle(2);
        wait_core(n);
        chk(ret_low > 0, "power-on left retained set");
        model(1, 1, 1, rsc_pkg::EV_POR);
        check_after(8'hf6);
        summarize();
    end
endmodule

// ### verilog/rsc_pin_filter.sv
`timescale 1ns/100ps
module rsc_pin_filter #(
    parameter int unsigned MIN_WIDTH = rsc_pkg::PIN_FILT_CYC
) (
    input  wire logic ref_clk_i,
    input  wire logic ce_i,
    input  wire logic rst_i,
    input  wire logic pin_low_i,
    output logic      pin_reset_o
);
    logic [15:0] width_cnt_r;

    // Only a low lasting MIN_WIDTH cycles is accepted; short glitches restart the count
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            width_cnt_r <= 16'h0000;
            pin_reset_o <= 1'b0;
        end else if (ce_i) begin
            if (!pin_low_i) begin
                width_cnt_r <= 16'h0000;
                pin_reset_o <= 1'b0;
            end else if (width_cnt_r >= 16'(MIN_WIDTH - 1)) begin
                pin_reset_o <= 1'b1;
            end else begin
                width_cnt_r <= width_cnt_r + 16'h0001;
            end
        end
    end
endmodule

// ### verilog/rsc_pkg.sv
package rsc_pkg;
    // Power-up hold: 64 ms nominal at 125 MHz
    localparam int unsigned PWRUP_MS       = 64;
    localparam int unsigned CLK_KHZ        = 125000;
    localparam int unsigned PWRUP_CYCLES   = PWRUP_MS * CLK_KHZ;
    // Pin filter default minimum accepted low width
    localparam int unsigned PIN_FILT_CYC   = 16;
    // Supply must sit at ground this long to re-arm power-on detection
    localparam int unsigned REARM_US       = 100;
    localparam int unsigned REARM_CYCLES   = REARM_US * CLK_KHZ / 1000;
    localparam int unsigned CNT_W          = 24;
    // Reset cause codes
    localparam logic [2:0] CAUSE_NONE      = 3'h0;
    localparam logic [2:0] CAUSE_POR       = 3'h1;
    localparam logic [2:0] CAUSE_BOR       = 3'h2;
    localparam logic [2:0] CAUSE_WDT_RUN   = 3'h3;
    localparam logic [2:0] CAUSE_WDT_SLEEP = 3'h4;
    localparam logic [2:0] CAUSE_PIN_RUN   = 3'h5;
    localparam logic [2:0] CAUSE_PIN_SLEEP = 3'h6;
    localparam logic [2:0] CAUSE_WDT_WAKE  = 3'h7;
    // Register map
    localparam logic [3:0] ADDR_STATUS     = 4'h0;
    localparam logic [3:0] ADDR_MASK       = 4'h1;
    localparam logic [3:0] ADDR_CAUSE      = 4'h2;
    localparam logic [3:0] ADDR_CTRL       = 4'h3;
    // Event bit positions in status and mask
    localparam int unsigned EV_POR         = 0;
    localparam int unsigned EV_BOR         = 1;
    localparam int unsigned EV_WDT         = 2;
    localparam int unsigned EV_PIN         = 3;
    localparam int unsigned EV_WAKE        = 4;
    localparam int unsigned EV_W           = 5;
    // Cause register field positions
    localparam int unsigned CF_BROWNOUT    = 0;
    localparam int unsigned CF_POWERDOWN   = 1;
    localparam int unsigned CF_TIMEOUT     = 2;
    localparam int unsigned CF_CODE_LO     = 4;
    // Control register fields
    localparam int unsigned CT_SLEEP       = 0;
    localparam int unsigned CT_BROWNOUT_SET = 1;
    localparam logic [7:0] MASK_RST        = 8'h00;
endpackage

// ### verilog/rsc_reset_ctrl.sv
// Behaviour
// - Distinguish six reset causes
// - Retained registers keep contents except power-on
// - Other registers reset on all true resets
// - Watchdog wake-up loads no reset values
// - Timeout and powerdown flags encode the cause
// - Filter rejects short external pin pulses
// - Watchdog reset never drives the pin
// - Power-on holds reset until supply good
// - Brown-out holds reset until threshold reached
// - Power-on re-arms only after supply at ground
// - Pin ignored when pin enable is zero
// - Pin enabled: active-low reset, pull-up on
// - Power-up timer holds reset, disable skips
// - Brown-out flag cleared only by brown-out
`timescale 1ns/100ps
module rsc_reset_ctrl #(
    parameter int unsigned PWRUP_CYCLES = rsc_pkg::PWRUP_CYCLES,
    parameter int unsigned PIN_MIN_CYC  = rsc_pkg::PIN_FILT_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    input  wire logic       supply_good_i,
    input  wire logic       supply_at_ground_i,
    input  wire logic       brownout_enable_i,
    input  wire logic       brownout_ok_i,
    input  wire logic       watchdog_timer_expired_i,
    input  wire logic       shared_input_pin_i,
    input  wire logic       ext_reset_pin_enable_i,
    input  wire logic       powerup_delay_disable_i,
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic            shared_pin_pullup_o,
    output logic            shared_pin_oe_n_o,
    output logic            shared_pin_gpio_o,
    output logic            core_rst_n_o,
    output logic            retained_rst_n_o,
    output logic            wake_o,
    output logic            irq_o
);
    typedef enum logic [1:0] {
        RSC_RUN   = 2'b00,
        RSC_HOLD  = 2'b01,
        RSC_TIMER = 2'b10
    } rsc_state_e;

    rsc_state_e  state_r;
    logic [1:0]  good_sync_r;
    logic [1:0]  gnd_sync_r;
    logic [1:0]  bor_sync_r;
    logic [1:0]  wdt_sync_r;
    logic [1:0]  pin_sync_r;
    logic        por_armed_r;
    logic [15:0] gnd_cnt_r;
    logic [31:0] pwrup_cnt_r;
    logic        rst_req_n_r;
    logic        core_rst_n_r;
    logic        retained_rst_n_r;
    logic        wake_r;
    logic        timeout_flag_n_r;
    logic        powerdown_flag_n_r;
    logic        brownout_clear_r;
    logic [2:0]  cause_r;
    logic        sleep_r;
    logic [rsc_pkg::EV_W-1:0] status_r;
    logic [rsc_pkg::EV_W-1:0] mask_r;
    logic [rsc_pkg::EV_W-1:0] ev_set;
    logic        pin_filtered;
    logic        por_event;
    logic        bor_low;
    logic        wdt_event;
    logic        pin_event;
    logic        in_reset;
    logic        wdt_prev_r;
    logic        pin_prev_r;

    // Two-flop synchronisers for all off-domain inputs
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            good_sync_r <= 2'b00;
            gnd_sync_r  <= 2'b00;
            bor_sync_r  <= 2'b00;
            wdt_sync_r  <= 2'b00;
            pin_sync_r  <= 2'b11;
        end else if (ce_i) begin
            good_sync_r <= {good_sync_r[0], supply_good_i};
            gnd_sync_r  <= {gnd_sync_r[0], supply_at_ground_i};
            bor_sync_r  <= {bor_sync_r[0], brownout_ok_i};
            wdt_sync_r  <= {wdt_sync_r[0], watchdog_timer_expired_i};
            pin_sync_r  <= {pin_sync_r[0], shared_input_pin_i};
        end
    end

    rsc_pin_filter #(
        .MIN_WIDTH (PIN_MIN_CYC)
    ) u_filter (
        .ref_clk_i   (ref_clk_i),
        .ce_i        (ce_i),
        .rst_i       (sys_rst_i),
        .pin_low_i   (ext_reset_pin_enable_i & ~pin_sync_r[1]),
        .pin_reset_o (pin_filtered)
    );

    // Supply droop does not retrigger power-on; only a ground dwell re-arms it
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            por_armed_r <= 1'b1;
            gnd_cnt_r   <= 16'h0000;
        end else if (ce_i) begin
            if (!gnd_sync_r[1]) begin
                gnd_cnt_r <= 16'h0000;
            end else if (gnd_cnt_r >= 16'(rsc_pkg::REARM_CYCLES - 1)) begin
                por_armed_r <= 1'b1;
            end else begin
                gnd_cnt_r <= gnd_cnt_r + 16'h0001;
            end
            if (por_armed_r && good_sync_r[1] && state_r == RSC_TIMER) begin
                por_armed_r <= 1'b0;
            end
        end
    end

    assign por_event = por_armed_r;
    assign bor_low   = brownout_enable_i & ~bor_sync_r[1];
    // Watchdog resets on its rising edge so one request yields one reset; the pin resets on the filtered level, its edge only sets status
    assign wdt_event = wdt_sync_r[1] & ~wdt_prev_r;
    assign pin_event = pin_filtered & ~pin_prev_r;
    assign in_reset  = (state_r != RSC_RUN);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wdt_prev_r <= 1'b0;
            pin_prev_r <= 1'b0;
        end else if (ce_i) begin
            wdt_prev_r <= wdt_sync_r[1];
            pin_prev_r <= pin_filtered;
        end
    end

    // Reset sequencer
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_r     <= RSC_HOLD;
            pwrup_cnt_r <= 32'h0000_0000;
        end else if (ce_i) begin
            unique case (state_r)
                RSC_RUN: begin
                    // A re-armed power-on detector must take the chip back into reset
                    if (por_event || bor_low || pin_filtered || (wdt_event && !sleep_r)) begin
                        state_r <= RSC_HOLD;
                    end
                end
                RSC_HOLD: begin
                    pwrup_cnt_r <= 32'h0000_0000;
                    if ((!por_event || good_sync_r[1]) && !bor_low && !pin_filtered) begin
                        state_r <= RSC_TIMER;
                    end
                end
                RSC_TIMER: begin
                    if (bor_low || pin_filtered || (por_event && !good_sync_r[1])) begin
                        state_r <= RSC_HOLD;
                    end else if (powerup_delay_disable_i
                                 || !(cause_r == rsc_pkg::CAUSE_POR
                                      || cause_r == rsc_pkg::CAUSE_BOR)
                                 || pwrup_cnt_r >= PWRUP_CYCLES - 1) begin
                        state_r <= RSC_RUN;
                    end else begin
                        pwrup_cnt_r <= pwrup_cnt_r + 32'h0000_0001;
                    end
                end
                default: begin
                    state_r <= RSC_HOLD;
                end
            endcase
        end
    end

    // Cause capture and the inverted flags
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cause_r            <= rsc_pkg::CAUSE_POR;
            timeout_flag_n_r   <= 1'b1;
            powerdown_flag_n_r <= 1'b1;
            brownout_clear_r   <= 1'b0;
        end else if (ce_i) begin
            if (por_event && !in_reset) begin
                cause_r <= rsc_pkg::CAUSE_POR;
            end else if (state_r == RSC_HOLD && por_event) begin
                cause_r            <= rsc_pkg::CAUSE_POR;
                timeout_flag_n_r   <= 1'b1;
                powerdown_flag_n_r <= 1'b1;
            end else if (!in_reset && bor_low) begin
                cause_r            <= rsc_pkg::CAUSE_BOR;
                timeout_flag_n_r   <= 1'b1;
                powerdown_flag_n_r <= 1'b1;
                brownout_clear_r   <= 1'b0;
            end else if (!in_reset && pin_filtered) begin
                cause_r <= sleep_r ? rsc_pkg::CAUSE_PIN_SLEEP : rsc_pkg::CAUSE_PIN_RUN;
                powerdown_flag_n_r <= ~sleep_r;
            end else if (!in_reset && wdt_event) begin
                cause_r            <= sleep_r ? rsc_pkg::CAUSE_WDT_WAKE
                                              : rsc_pkg::CAUSE_WDT_RUN;
                timeout_flag_n_r   <= 1'b0;
                powerdown_flag_n_r <= ~sleep_r;
            end else if (reg_wr_i && reg_addr_i == rsc_pkg::ADDR_CTRL
                         && reg_wdata_i[rsc_pkg::CT_BROWNOUT_SET]) begin
                brownout_clear_r <= 1'b1;
            end
        end
    end

    // Sleep state comes from the core; any wake or reset ends it
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sleep_r <= 1'b0;
            wake_r  <= 1'b0;
        end else if (ce_i) begin
            wake_r <= sleep_r && wdt_event && !in_reset;
            if (in_reset || (sleep_r && wdt_event)) begin
                sleep_r <= 1'b0;
            end else if (reg_wr_i && reg_addr_i == rsc_pkg::ADDR_CTRL) begin
                sleep_r <= reg_wdata_i[rsc_pkg::CT_SLEEP];
            end
        end
    end

    // Release is registered so reset leaves on a clock edge
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rst_req_n_r      <= 1'b0;
            core_rst_n_r     <= 1'b0;
            retained_rst_n_r <= 1'b0;
        end else if (ce_i) begin
            rst_req_n_r      <= ~in_reset;
            core_rst_n_r     <= rst_req_n_r;
            // Samples the same request stage as the core reset so retained never drops without the core
            retained_rst_n_r <= rst_req_n_r || (cause_r != rsc_pkg::CAUSE_POR);
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    always_comb begin
        ev_set = '0;
        ev_set[rsc_pkg::EV_POR]  = state_r == RSC_HOLD && por_event;
        ev_set[rsc_pkg::EV_BOR]  = !in_reset && bor_low;
        ev_set[rsc_pkg::EV_WDT]  = !in_reset && wdt_event && !sleep_r;
        ev_set[rsc_pkg::EV_PIN]  = !in_reset && pin_event;
        ev_set[rsc_pkg::EV_WAKE] = !in_reset && wdt_event && sleep_r;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            status_r <= '0;
            mask_r   <= rsc_pkg::MASK_RST[rsc_pkg::EV_W-1:0];
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == rsc_pkg::ADDR_STATUS) begin
                status_r <= (status_r & ~reg_wdata_i[rsc_pkg::EV_W-1:0]) | ev_set;
            end else begin
                status_r <= status_r | ev_set;
            end
            if (reg_wr_i && reg_addr_i == rsc_pkg::ADDR_MASK) begin
                mask_r <= reg_wdata_i[rsc_pkg::EV_W-1:0];
            end
        end
    end

    // Read data valid the cycle after the strobe only
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            reg_rdata_o <= 8'h00;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    rsc_pkg::ADDR_STATUS: reg_rdata_o <= {3'h0, status_r};
                    rsc_pkg::ADDR_MASK:   reg_rdata_o <= {3'h0, mask_r};
                    rsc_pkg::ADDR_CAUSE:  reg_rdata_o <= {1'b0, cause_r, 1'b0,
                                                          timeout_flag_n_r,
                                                          powerdown_flag_n_r,
                                                          brownout_clear_r};
                    rsc_pkg::ADDR_CTRL:   reg_rdata_o <= {7'h00, sleep_r};
                    default:              reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // Pin is input only; watchdog reset never pulls it low
    assign shared_pin_oe_n_o   = 1'b1;
    assign shared_pin_gpio_o   = ~ext_reset_pin_enable_i & pin_sync_r[1];
    assign shared_pin_pullup_o = ext_reset_pin_enable_i;
    assign core_rst_n_o        = core_rst_n_r;
    assign retained_rst_n_o    = retained_rst_n_r;
    assign wake_o              = wake_r;
    assign irq_o               = |(status_r & mask_r);
endmodule
